// >>> src/stw_pkg.sv
// Purpose: Shared constants and types for the two-wire bus master
// Assumes: 40 MHz system clock, open-drain SCL and SDA with pull-ups
// Notes: Timing counts derive from the rates below
package stw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QUARTER_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int SCL_LOW_TMO_MS = 25;
  localparam int SCL_LOW_TMO_CYC = SCL_LOW_TMO_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 16;
  localparam int TMO_W = 24;

  // ----------------------------------------------------------------
  // Byte framing and bit phases
  // ----------------------------------------------------------------
  localparam logic [3:0] ACK_IDX = 4'h8;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_ADDR = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ = 3'h3,
    CMD_STOP = 3'h4
  } stw_kind_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HOLD = 5'h02,
    ST_STA = 5'h04,
    ST_BITS = 5'h08,
    ST_STO = 5'h10
  } stw_state_type;

  typedef struct packed {
    stw_kind_type kind;
    logic [6:0] addr;
    logic rnw;
    logic [7:0] data;
    logic nack;
  } stw_cmd_type;

  typedef struct packed {
    logic [7:0] data;
    logic ackSeen;
    logic arbLost;
    logic timeout;
    logic refused;
  } stw_rsp_type;

  localparam stw_rsp_type RSP_RESET = '{data: 8'h00, ackSeen: 1'b0, arbLost: 1'b0,
                                        timeout: 1'b0, refused: 1'b0};

endpackage : stw_pkg

// >>> src/stw_sync.sv
// Purpose: Two-stage synchroniser for bus line inputs
// Assumes: Lines idle high, so both stages reset to one
// Notes: Only the second stage leaves this module
`timescale 1ns/10ps
module stw_sync
  import stw_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------
  // Per-bit flops
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1_ff;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        stage1_ff[i] <= 1'b1;
        dout[i] <= 1'b1;
      end else begin
        stage1_ff[i] <= din[i];
        dout[i] <= stage1_ff[i];
      end
    end
  end

endmodule : stw_sync

// >>> src/stw_host.sv
// Purpose: Byte-command master that drives a two-wire bus device
// Assumes: One command at a time; pins resolved outside as open drain
// Notes: Quarter-bit sequencer with clock stretching and SCL low timeout
`timescale 1ns/10ps
module stw_host
  import stw_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC,
  parameter int SCL_TMO = SCL_LOW_TMO_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire stw_cmd_type cmd,
  output logic rspValid,
  output stw_rsp_type rsp,
  output logic busOwned,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  // ----------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] Q_LOAD = CNT_W'(QUARTER - 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(SCL_TMO - 1);

  logic [1:0] lineSync;
  logic sclHigh;
  logic sdaHigh;
  stw_state_type state_ff, nxt_state;
  logic [1:0] phase_ff, nxt_phase;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [3:0] bitIdx_ff, nxt_bitIdx;
  logic [7:0] shift_ff, nxt_shift;
  logic isRead_ff, nxt_isRead;
  logic nack_ff, nxt_nack;
  logic ackSeen_ff, nxt_ackSeen;
  logic sclOe_ff, nxt_sclOe;
  logic sdaOe_ff, nxt_sdaOe;
  logic [TMO_W-1:0] tmo_ff, nxt_tmo;
  logic rspValid_ff, nxt_rspValid;
  stw_rsp_type rsp_ff, nxt_rsp;
  logic cmdReady_ff, nxt_cmdReady;
  logic busOwned_ff, nxt_busOwned;
  logic lineLow_ff;
  logic cmdFire;
  logic done;
  logic tmoHit;
  logic [7:0] addrByte;

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  stw_sync #(.WIDTH(2)) uSync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({sclIn, sdaIn}),
    .dout(lineSync)
  );

  assign sclHigh = lineSync[1];
  assign sdaHigh = lineSync[0];
  assign cmdFire = cmdValid && cmdReady_ff;
  assign done = (cnt_ff == '0);
  assign tmoHit = (tmo_ff == TMO_LAST);
  assign addrByte = {cmd.addr, cmd.rnw};

  function automatic logic bitDrive(input logic [3:0] idx, input logic [7:0] sh,
                                    input logic rd, input logic nk);
    if (idx == ACK_IDX) begin
      bitDrive = rd && !nk;
    end else begin
      bitDrive = !rd && !sh[7];
    end
  endfunction : bitDrive

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_cnt = done ? cnt_ff : cnt_ff - 1'b1;
    nxt_bitIdx = bitIdx_ff;
    nxt_shift = shift_ff;
    nxt_isRead = isRead_ff;
    nxt_nack = nack_ff;
    nxt_ackSeen = ackSeen_ff;
    nxt_sclOe = sclOe_ff;
    nxt_sdaOe = sdaOe_ff;
    nxt_rspValid = 1'b0;
    nxt_rsp = rsp_ff;
    if (state_ff != ST_IDLE && !sclHigh && !sclOe_ff) begin
      nxt_tmo = tmoHit ? tmo_ff : tmo_ff + 1'b1;
    end else begin
      nxt_tmo = '0;
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_sclOe = 1'b0;
        nxt_sdaOe = 1'b0;
        if (cmdFire) begin
          if (cmd.kind == CMD_START) begin
            nxt_state = ST_STA;
            nxt_phase = PH_SETUP;
            nxt_cnt = Q_LOAD;
          end else begin
            nxt_rspValid = 1'b1;
            nxt_rsp = RSP_RESET;
            nxt_rsp.refused = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (cmdFire) begin
          nxt_phase = PH_SETUP;
          nxt_cnt = Q_LOAD;
          nxt_bitIdx = 4'h0;
          nxt_nack = cmd.nack;
          case (cmd.kind)
            CMD_START: begin
              nxt_state = ST_STA;
              nxt_sdaOe = 1'b0;
            end
            CMD_ADDR: begin
              nxt_state = ST_BITS;
              nxt_shift = addrByte;
              nxt_isRead = 1'b0;
              nxt_sdaOe = !addrByte[7];
            end
            CMD_WRITE: begin
              nxt_state = ST_BITS;
              nxt_shift = cmd.data;
              nxt_isRead = 1'b0;
              nxt_sdaOe = !cmd.data[7];
            end
            CMD_READ: begin
              nxt_state = ST_BITS;
              nxt_isRead = 1'b1;
              nxt_sdaOe = 1'b0;
            end
            CMD_STOP: begin
              nxt_state = ST_STO;
              nxt_sdaOe = 1'b1;
            end
            default: begin
              nxt_state = ST_HOLD;
            end
          endcase
        end
      end
      ST_STA: begin
        case (phase_ff)
          PH_SETUP: begin
            nxt_sdaOe = 1'b0;
            if (done) begin
              nxt_sclOe = 1'b0;
              nxt_phase = PH_RISE;
              nxt_cnt = Q_LOAD;
            end
          end
          PH_RISE: begin
            if (!(sclHigh && sdaHigh)) begin
              nxt_cnt = Q_LOAD;
            end else if (done) begin
              nxt_sdaOe = 1'b1;
              nxt_phase = PH_HIGH;
              nxt_cnt = Q_LOAD;
            end
          end
          PH_HIGH: begin
            if (done) begin
              nxt_sclOe = 1'b1;
              nxt_phase = PH_FALL;
              nxt_cnt = Q_LOAD;
            end
          end
          default: begin
            if (done) begin
              nxt_state = ST_HOLD;
              nxt_rspValid = 1'b1;
              nxt_rsp = RSP_RESET;
            end
          end
        endcase
      end
      ST_BITS: begin
        case (phase_ff)
          PH_SETUP: begin
            if (done) begin
              nxt_sclOe = 1'b0;
              nxt_phase = PH_RISE;
              nxt_cnt = Q_LOAD;
            end
          end
          PH_RISE: begin
            if (!sclHigh) begin
              nxt_cnt = Q_LOAD;
            end else if (done) begin
              nxt_phase = PH_HIGH;
              nxt_cnt = Q_LOAD;
            end
          end
          PH_HIGH: begin
            if (done) begin
              nxt_sclOe = 1'b1;
              nxt_phase = PH_FALL;
              nxt_cnt = Q_LOAD;
              if (bitIdx_ff == ACK_IDX) begin
                nxt_ackSeen = !sdaHigh;
              end else begin
                nxt_shift = {shift_ff[6:0], sdaHigh};
                if (!isRead_ff && !sdaOe_ff && !sdaHigh) begin
                  nxt_state = ST_IDLE;
                  nxt_sclOe = 1'b0;
                  nxt_sdaOe = 1'b0;
                  nxt_rspValid = 1'b1;
                  nxt_rsp = RSP_RESET;
                  nxt_rsp.arbLost = 1'b1;
                end
              end
            end
          end
          default: begin
            if (done) begin
              if (bitIdx_ff == ACK_IDX) begin
                nxt_state = ST_HOLD;
                nxt_rspValid = 1'b1;
                nxt_rsp = RSP_RESET;
                nxt_rsp.data = shift_ff;
                nxt_rsp.ackSeen = ackSeen_ff;
              end else begin
                nxt_bitIdx = bitIdx_ff + 1'b1;
                nxt_phase = PH_SETUP;
                nxt_cnt = Q_LOAD;
                nxt_sdaOe = bitDrive(bitIdx_ff + 1'b1, shift_ff, isRead_ff, nack_ff);
              end
            end
          end
        endcase
      end
      ST_STO: begin
        case (phase_ff)
          PH_SETUP: begin
            nxt_sdaOe = 1'b1;
            if (done) begin
              nxt_sclOe = 1'b0;
              nxt_phase = PH_RISE;
              nxt_cnt = Q_LOAD;
            end
          end
          PH_RISE: begin
            if (!sclHigh) begin
              nxt_cnt = Q_LOAD;
            end else if (done) begin
              nxt_sdaOe = 1'b0;
              nxt_phase = PH_HIGH;
              nxt_cnt = Q_LOAD;
            end
          end
          default: begin
            if (done) begin
              nxt_state = ST_IDLE;
              nxt_rspValid = 1'b1;
              nxt_rsp = RSP_RESET;
            end
          end
        endcase
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (tmoHit && state_ff != ST_IDLE) begin
      nxt_state = ST_IDLE;
      nxt_sclOe = 1'b0;
      nxt_sdaOe = 1'b0;
      nxt_rspValid = 1'b1;
      nxt_rsp = RSP_RESET;
      nxt_rsp.timeout = 1'b1;
    end
    nxt_cmdReady = (nxt_state == ST_IDLE) || (nxt_state == ST_HOLD);
    nxt_busOwned = (nxt_state != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_SETUP;
      cnt_ff <= '0;
      bitIdx_ff <= 4'h0;
      shift_ff <= SHIFT_RESET;
      isRead_ff <= 1'b0;
      nack_ff <= 1'b0;
      ackSeen_ff <= 1'b0;
      sclOe_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      tmo_ff <= '0;
      rspValid_ff <= 1'b0;
      rsp_ff <= RSP_RESET;
      cmdReady_ff <= 1'b0;
      busOwned_ff <= 1'b0;
      lineLow_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      bitIdx_ff <= nxt_bitIdx;
      shift_ff <= nxt_shift;
      isRead_ff <= nxt_isRead;
      nack_ff <= nxt_nack;
      ackSeen_ff <= nxt_ackSeen;
      sclOe_ff <= nxt_sclOe;
      sdaOe_ff <= nxt_sdaOe;
      tmo_ff <= nxt_tmo;
      rspValid_ff <= nxt_rspValid;
      rsp_ff <= nxt_rsp;
      cmdReady_ff <= nxt_cmdReady;
      busOwned_ff <= nxt_busOwned;
      lineLow_ff <= 1'b0;
    end
  end

  assign cmdReady = cmdReady_ff;
  assign rspValid = rspValid_ff;
  assign rsp = rsp_ff;
  assign busOwned = busOwned_ff;
  assign sclOe = sclOe_ff;
  assign sdaOe = sdaOe_ff;
  assign sclOut = lineLow_ff;
  assign sdaOut = lineLow_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  addr_byte_a: assert property (cmdFire && state_ff == ST_HOLD && cmd.kind == CMD_ADDR
    |=> state_ff == ST_BITS && shift_ff == $past(addrByte))
    else $error("address byte not loaded");
  rw_dir_a: assert property (cmdFire && state_ff == ST_HOLD && cmd.kind == CMD_ADDR
    |=> shift_ff[0] == $past(addrByte[0]) && !isRead_ff && sdaOe_ff == !$past(addrByte[7]))
    else $error("direction bit misplaced");
  tx_bit_a: assert property (state_ff == ST_BITS && phase_ff == PH_RISE && !isRead_ff
    && bitIdx_ff < ACK_IDX |-> sdaOe_ff == !shift_ff[7])
    else $error("transmit bit wrong");
  rx_release_a: assert property (state_ff == ST_BITS && isRead_ff
    && bitIdx_ff < ACK_IDX |-> !sdaOe_ff)
    else $error("SDA driven during read data");
  ack_drive_a: assert property (state_ff == ST_BITS && bitIdx_ff == ACK_IDX
    |-> sdaOe_ff == (isRead_ff && !nack_ff))
    else $error("acknowledge drive wrong");
  ack_wait_a: assert property (state_ff == ST_BITS && nxt_state == ST_HOLD
    |-> bitIdx_ff == ACK_IDX && phase_ff == PH_FALL ##1 rspValid_ff && cmdReady_ff)
    else $error("byte ended before acknowledge");
  start_cond_a: assert property ($rose(sdaOe_ff) && state_ff == ST_STA
    |-> !sclOe_ff && $past(sclHigh) && $past(sdaHigh))
    else $error("START without SCL high");
  stop_cond_a: assert property ($fell(sdaOe_ff) && state_ff == ST_STO
    |-> !sclOe_ff ##[1:2] 1'b1 ##0 state_ff == ST_STO || state_ff == ST_IDLE)
    else $error("STOP not completed");
  owner_flag_a: assert property (busOwned_ff == (state_ff != ST_IDLE))
    else $error("ownership flag mismatch");
  stretch_wait_a: assert property (state_ff == ST_BITS && phase_ff == PH_RISE
    && !sclHigh && !tmoHit |=> state_ff == ST_BITS && phase_ff == PH_RISE && cnt_ff == Q_LOAD)
    else $error("SCL stretch not honoured");
  open_drain_a: assert property (!sclOut && !sdaOut
    && (state_ff != ST_IDLE || !$past(state_ff == ST_IDLE) || (!sclOe_ff && !sdaOe_ff)))
    else $error("line driven high or held in idle");
  scl_tmo_a: assert property (tmoHit && state_ff != ST_IDLE
    |=> state_ff == ST_IDLE && !sclOe_ff && !sdaOe_ff && rspValid_ff && rsp_ff.timeout)
    else $error("SCL low timeout not handled");
  sda_edge_a: assert property ($changed(sdaOe_ff) && state_ff != ST_IDLE
    |-> $past(sclOe_ff) || (phase_ff == PH_HIGH && (state_ff == ST_STA || state_ff == ST_STO)))
    else $error("SDA moved while SCL high");

  write_ack_c: cover property (rspValid_ff && rsp_ff.ackSeen && !isRead_ff);
  read_byte_c: cover property (rspValid_ff && isRead_ff && $past(state_ff == ST_BITS));
  stretch_c: cover property (state_ff == ST_BITS && phase_ff == PH_RISE && !sclHigh [*8]);
  timeout_c: cover property (rspValid_ff && rsp_ff.timeout);

endmodule : stw_host

// >>> test/stw_dev_model.sv
// Purpose: Behavioural slave device on the two-wire bus
// Assumes: Lines resolved outside with pull-ups
// Notes: Reads return the bytes last written, in order
`timescale 1ns/10ps
module stw_dev_model
  import stw_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h52
) (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] stretch,
  input wire logic holdLow,
  output logic sclDrv,
  output logic sdaDrv,
  output int starts,
  output int stops,
  output logic [3:0][7:0] mem
);
  logic sclQ = 1'b1;
  logic sdaQ = 1'b1;
  logic act = 1'b0;
  logic adr = 1'b0;
  logic rd = 1'b0;
  logic txOn = 1'b0;
  logic mAck = 1'b0;
  logic sd = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  int bitN = 0;
  int wp = 0;
  int rp = 0;
  int hold = 0;
  int nStarts = 0;
  int nStops = 0;
  logic [3:0][7:0] memQ = '0;

  assign starts = nStarts;
  assign stops = nStops;
  assign mem = memQ;

  // ----------------------------------------------------------------
  // Bus follower
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (hold > 0) hold--;
    if (sclQ && scl && sdaQ && !sda) begin
      nStarts++;
      act = 1'b1;
      adr = 1'b1;
      txOn = 1'b0;
      sd = 1'b0;
      bitN = -1;
      wp = 0;
      rp = 0;
    end else if (sclQ && scl && !sdaQ && sda) begin
      nStops++;
      act = 1'b0;
      sd = 1'b0;
    end else if (act && !sclQ && scl) begin
      if (bitN < 8) sh = {sh[6:0], sda};
      else mAck = !sda;
    end else if (act && sclQ && !scl) begin
      hold = stretch;
      if (bitN == 7) begin
        sd = 1'b0;
        if (adr) begin
          rd = sh[0];
          sd = (sh[7:1] == DEV_ADDR);
        end else if (!rd) begin
          memQ[wp] = sh;
          wp = (wp + 1) % 4;
          sd = 1'b1;
        end
      end else if (bitN == 8) begin
        sd = 1'b0;
        if (adr && sh[7:1] != DEV_ADDR) act = 1'b0;
        txOn = act && rd && (adr || mAck);
        adr = 1'b0;
        if (txOn) begin
          tx = memQ[rp];
          rp = (rp + 1) % 4;
          sd = !tx[7];
        end
      end else if (txOn) sd = !tx[6 - bitN];
      bitN = (bitN == 8) ? 0 : bitN + 1;
    end
    sclQ = scl;
    sdaQ = sda;
    sdaDrv <= sd;
    sclDrv <= holdLow || hold > 0;
  end
endmodule : stw_dev_model

// >>> test/test_stw_host.sv
// Purpose: Self-checking bench for the two-wire bus master
// Assumes: Short quarter and timeout counts keep the run brief
// Notes: A behavioural slave and bench pull-downs share the lines
`timescale 1ns/10ps
module test_stw_host;
  import stw_pkg::*;
  localparam int Q = 4;
  localparam int TMO = 200;
  localparam logic [6:0] DEV = 7'h52;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic tbScl = 1'b0;
  logic tbSda = 1'b0;
  logic holdLow = 1'b0;
  logic [7:0] stretch = 8'h00;
  stw_cmd_type cmd = '0;
  stw_rsp_type rsp, got;
  logic cmdReady, rspValid, busOwned, sclOe, sdaOe, devScl, devSda, sclOut, sdaOut;
  logic [3:0][7:0] mem;
  int starts, stops, el;
  int fails = 0;
  int num_checks = 0;
  int hiRun = 0;
  int loRun = 0;
  int minHi = 999;
  int minLo = 999;
  realtime t0;
  wire scl = !(sclOe || devScl || tbScl);
  wire sda = !(sdaOe || devSda || tbSda);

  stw_host #(.QUARTER(Q), .SCL_TMO(TMO)) stw_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .rspValid(rspValid), .rsp(rsp), .busOwned(busOwned), .sclIn(scl), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe)
  );
  stw_dev_model #(.DEV_ADDR(DEV)) stw_dev_model_inst (
    .clk_sys(clk_sys), .scl(scl), .sda(sda), .stretch(stretch), .holdLow(holdLow),
    .sclDrv(devScl), .sdaDrv(devSda), .starts(starts), .stops(stops), .mem(mem)
  );

  always #12.5 clk_sys = !clk_sys;

  // ----------------------------------------------------------------
  // Shortest SCL phases while the bus is owned
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (busOwned && scl) begin
      if (loRun > 0 && loRun < minLo) minLo = loRun;
      loRun = 0;
      hiRun++;
    end else if (busOwned) begin
      if (hiRun > 0 && hiRun < minHi) minHi = hiRun;
      hiRun = 0;
      loRun++;
    end else begin
      hiRun = 0;
      loRun = 0;
    end
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task send(input stw_kind_type k, input logic [7:0] b = 8'h00, input logic n = 1'b0);
    int i;
    i = 0;
    cmd = '{kind: k, addr: b[7:1], rnw: b[0], data: b, nack: n};
    cmdValid = 1'b1;
    while (!cmdReady && i < 9000) begin
      @(negedge clk_sys);
      i++;
    end
    @(negedge clk_sys);
    cmdValid = 1'b0;
    while (!rspValid && i < 9000) begin
      @(negedge clk_sys);
      i++;
    end
    got = rsp;
    if (i >= 9000) begin
      fails++;
      test_done;
    end
  endtask : send

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task test_refuse;
    stw_kind_type k;
    k = CMD_ADDR;
    repeat (4) begin
      send(k, 8'h11);
      check(8'(got.refused), 8'h01);
      check(8'({busOwned, sclOe, sdaOe}), 8'h00);
      @(negedge clk_sys);
      k = k.next();
    end
  endtask : test_refuse

  task test_write_read;
    send(CMD_START);
    check(8'(busOwned), 8'h01);
    send(CMD_ADDR, {DEV, 1'b0});
    check(8'(got.ackSeen), 8'h01);
    send(CMD_WRITE, 8'ha5);
    check(8'(got.ackSeen), 8'h01);
    check(got.data, 8'ha5);
    send(CMD_WRITE, 8'h3c);
    check(mem[0], 8'ha5);
    check(mem[1], 8'h3c);
    send(CMD_START);
    send(CMD_ADDR, {DEV, 1'b1});
    check(8'(got.ackSeen), 8'h01);
    send(CMD_READ);
    check(got.data, 8'ha5);
    send(CMD_READ, 8'h00, 1'b1);
    check(got.data, 8'h3c);
    send(CMD_STOP);
    @(negedge clk_sys);
    check(8'({busOwned, scl, sda}), 8'h03);
    check(8'(starts), 8'h02);
    check(8'(stops), 8'h01);
  endtask : test_write_read

  task test_nack;
    send(CMD_START);
    send(CMD_ADDR, 8'h26);
    check(8'(got.ackSeen), 8'h00);
    send(CMD_STOP);
  endtask : test_nack

  task test_stretch;
    stretch = 8'd40;
    send(CMD_START);
    send(CMD_ADDR, {DEV, 1'b0});
    t0 = $realtime;
    send(CMD_WRITE, 8'h5a);
    el = int'(($realtime - t0) / 25.0);
    check(8'(got.ackSeen), 8'h01);
    check(mem[0], 8'h5a);
    check(8'(el >= 360), 8'h01);
    send(CMD_STOP);
    stretch = 8'h00;
  endtask : test_stretch

  task test_busy;
    tbScl = 1'b1;
    fork
      send(CMD_START);
      begin
        repeat (60) @(negedge clk_sys);
        check(8'({sdaOe, rspValid}), 8'h00);
        tbScl = 1'b0;
      end
    join
    check(8'(busOwned), 8'h01);
    send(CMD_STOP);
  endtask : test_busy

  task test_arb;
    send(CMD_START);
    tbSda = 1'b1;
    send(CMD_ADDR, 8'hff);
    check(8'(got.arbLost), 8'h01);
    @(negedge clk_sys);
    check(8'({busOwned, sclOe, sdaOe}), 8'h00);
    tbSda = 1'b0;
    repeat (5) @(negedge clk_sys);
  endtask : test_arb

  task test_timeout;
    send(CMD_START);
    send(CMD_ADDR, {DEV, 1'b0});
    holdLow = 1'b1;
    t0 = $realtime;
    send(CMD_WRITE, 8'h00);
    el = int'(($realtime - t0) / 25.0);
    check(8'(got.timeout), 8'h01);
    check(8'(el >= TMO && el <= TMO + 40), 8'h01);
    @(negedge clk_sys);
    check(8'({busOwned, sclOe, sdaOe}), 8'h00);
    holdLow = 1'b0;
    repeat (5) @(negedge clk_sys);
  endtask : test_timeout

  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(8'(cmdReady), 8'h01);
    check(8'({sclOe, sdaOe, busOwned}), 8'h00);
    check(8'({sclOut, sdaOut}), 8'h00);
    test_refuse;
    test_write_read;
    test_nack;
    test_stretch;
    test_busy;
    test_arb;
    test_timeout;
    check(8'(minHi >= Q && minLo >= Q), 8'h01);
    check(8'(minHi + minLo >= 10), 8'h01);
    check(8'({sclOut, sdaOut}), 8'h00);
    test_done;
  end
endmodule : test_stw_host
